// [hdl/lcs_pkg.sv]
// package: field layout, reset state and timing of the main control/status register
package lcs_pkg;

   // ************************************************
   // register geometry
   // ************************************************
   localparam int CSR_W = 16;
   localparam int BIT_ERR = 15;
   localparam int BIT_BABBLE_FLAG = 14;
   localparam int BIT_COLLISION_ERROR_FLAG = 13;
   localparam int BIT_MISS = 12;
   localparam int BIT_MEMORY_ERROR_FLAG = 11;
   localparam int BIT_RECEIVE_EVENT_FLAG = 10;
   localparam int BIT_TRANSMIT_EVENT_FLAG = 9;
   localparam int BIT_INITIALIZATION_DONE_FLAG = 8;
   localparam int BIT_INTERRUPT_SUMMARY_FLAG = 7;
   localparam int BIT_INTERRUPT_ENABLE_BIT = 6;
   localparam int BIT_RECEIVER_ON_STATUS = 5;
   localparam int BIT_TRANSMITTER_ON_STATUS = 4;
   localparam int BIT_TRANSMIT_DEMAND_BIT = 3;
   localparam int BIT_STOP = 2;
   localparam int BIT_START_COMMAND = 1;
   localparam int BIT_INIT = 0;
   localparam logic [15:0] CSR_RESET_VALUE = 16'h0004;

   // ************************************************
   // timing
   // ************************************************
   localparam int CLK_PERIOD_NS = 4;
   localparam int MEMORY_ERROR_FLAG_TIMEOUT_NS = 25600;
   // least wait, so round up to whole cycles
   localparam int MEMORY_ERROR_FLAG_TIMEOUT_CYC = (MEMORY_ERROR_FLAG_TIMEOUT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int BABBLE_BYTES = 1519;
   localparam int BYTE_CNT_W = 11;

   // ************************************************
   // carriers
   // ************************************************
   // one-cycle event pulses from the rest of the controller
   typedef struct packed {
      logic rx_done;
      logic rx_fail;
      logic tx_done;
      logic tx_fail;
      logic tx_underflow;
      logic tx_buffer_err;
      logic missed;
      logic collision_err;
      logic init_done;
      logic disable_receiver_setting;
      logic disable_transmitter_setting;
      logic transmit_demand_bit_taken;
      logic tx_frame_start;
      logic tx_byte;
   } lcs_evt_t;

   // whole register-block state
   typedef struct packed {
      logic babble_flag;
      logic collision_error_flag;
      logic miss;
      logic memory_error_flag;
      logic receive_event_flag;
      logic transmit_event_flag;
      logic initialization_done_flag;
      logic interrupt_enable_bit;
      logic receiver_on_status;
      logic transmitter_on_status;
      logic transmit_demand_bit;
      logic stop;
      logic start_command;
      logic init;
      logic params_ok;
      logic disable_receiver_setting;
      logic disable_transmitter_setting;
      logic [BYTE_CNT_W-1:0] byte_cnt;
      logic sel_d;
      logic [CSR_W-1:0] rdata;
      logic int_n;
      logic stop_pulse;
   } lcs_state_t;

   localparam lcs_state_t LCS_STATE_RST = '{stop: 1'b1, int_n: 1'b1, default: '0};

endpackage

// [hdl/lcs_mem_timeout.sv]
// module: bus master ready watchdog that raises a memory error pulse
module lcs_mem_timeout import lcs_pkg::*; #(
   parameter int TIMEOUT_CYC = MEMORY_ERROR_FLAG_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // master cycle
   input wire logic addr_strobe,
   input wire logic ready,
   input wire logic abort,
   // result
   output logic timeout
);

   localparam int CW = $clog2(TIMEOUT_CYC + 1);
   localparam logic [CW-1:0] LAST = CW'(TIMEOUT_CYC - 1);

   typedef struct packed {
      logic busy;
      logic [CW-1:0] cnt;
      logic timeout;
   } lcs_tmo_t;

   lcs_tmo_t r;
   lcs_tmo_t n;

   // ************************************************
   // wait counter
   // ************************************************
   // counting starts on the address phase and stops at ready
   always_comb begin
      n = r;
      n.timeout = 1'b0;
      if (abort || ready) begin
         n.busy = 1'b0;
         n.cnt = '0;
      end else if (addr_strobe) begin
         n.busy = 1'b1;
         n.cnt = '0;
      end else if (r.busy) begin
         if (r.cnt == LAST) begin
            n.busy = 1'b0;
            n.timeout = 1'b1;
         end else begin
            n.cnt = r.cnt + 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= '0;
      end else if (ce) begin
         r <= n;
      end
   end

   assign timeout = r.timeout;

endmodule

// [hdl/lcs_main_csr.sv]
// module: main control and status register of the network controller
//
// Notes on behaviour
// - memory error after 25.6 us without ready
// - memory error turns receiver and transmitter off
// - event flags: hardware set, write-one clear
// - receive flag on last buffer or failure
// - transmit flag on last buffer or failure
// - init-done flag once parameters are stored
// - interrupt summary ORs six flags, not collision
// - interrupt pin low when enabled and pending
// - summary read-only, clears with its causes
// - interrupt enable writable anytime, cleared by stop
// - receiver-on set by start unless disabled
// - transmitter-on set by start, cleared by errors
// - transmit demand polls now, then self-clears
// - stop acts like hardware reset
// - stop wins over start and initialize
// - stop set by reset, cleared by start/init
// - start taken whether stopped or not, clears stop
// - start set by writing one only
// - initialize fetches parameters, clears stop
// - register latched during a host read
// - error summary ORs four error flags
// - babble after 1519 transmitted bytes
// - missed packet flag when no buffer owned
module lcs_main_csr import lcs_pkg::*; #(
   parameter int MEMORY_ERROR_FLAG_CYC = MEMORY_ERROR_FLAG_TIMEOUT_CYC
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // host slave access
   input wire logic host_sel,
   input wire logic host_wr,
   input wire logic [CSR_W-1:0] host_wdata,
   output logic [CSR_W-1:0] host_rdata,
   // bus master watch
   input wire logic bm_addr_strobe,
   input wire logic bm_ready,
   // controller events
   input wire lcs_evt_t evt,
   // interrupt pin
   output logic int_n,
   // status towards the controller
   output logic rx_on,
   output logic tx_on,
   output logic transmit_demand_bit_pending,
   output logic start_on,
   output logic init_req,
   output logic stop_on,
   output logic stop_pulse
);

   lcs_state_t r;
   lcs_state_t n;

   logic memory_error_flag_evt;
   logic acc;
   logic wr;
   logic rd;
   logic wr_stop;
   logic [CSR_W-1:0] clr;
   logic [CSR_W-1:0] csr;
   logic interrupt_summary_flag;
   logic err;
   logic run;
   logic babble_flag_set;
   logic tx_kill;

   // ************************************************
   // memory error watchdog
   // ************************************************
   // stop drops any master cycle, so the watch is aborted too
   lcs_mem_timeout #(
      .TIMEOUT_CYC(MEMORY_ERROR_FLAG_CYC)
   ) u_tmo (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .addr_strobe(bm_addr_strobe),
      .ready(bm_ready),
      .abort(r.stop),
      .timeout(memory_error_flag_evt)
   );

   // ************************************************
   // register view
   // ************************************************
   // summary bits are derived, never stored, so they follow their causes
   assign interrupt_summary_flag = r.babble_flag | r.miss | r.memory_error_flag | r.receive_event_flag | r.transmit_event_flag | r.initialization_done_flag;
   assign err = r.babble_flag | r.collision_error_flag | r.miss | r.memory_error_flag;

   // read image of the register
   always_comb begin
      csr = '0;
      csr[BIT_ERR] = err;
      csr[BIT_BABBLE_FLAG] = r.babble_flag;
      csr[BIT_COLLISION_ERROR_FLAG] = r.collision_error_flag;
      csr[BIT_MISS] = r.miss;
      csr[BIT_MEMORY_ERROR_FLAG] = r.memory_error_flag;
      csr[BIT_RECEIVE_EVENT_FLAG] = r.receive_event_flag;
      csr[BIT_TRANSMIT_EVENT_FLAG] = r.transmit_event_flag;
      csr[BIT_INITIALIZATION_DONE_FLAG] = r.initialization_done_flag;
      csr[BIT_INTERRUPT_SUMMARY_FLAG] = interrupt_summary_flag;
      csr[BIT_INTERRUPT_ENABLE_BIT] = r.interrupt_enable_bit;
      csr[BIT_RECEIVER_ON_STATUS] = r.receiver_on_status;
      csr[BIT_TRANSMITTER_ON_STATUS] = r.transmitter_on_status;
      csr[BIT_TRANSMIT_DEMAND_BIT] = r.transmit_demand_bit;
      csr[BIT_STOP] = r.stop;
      csr[BIT_START_COMMAND] = r.start_command;
      csr[BIT_INIT] = r.init;
   end

   // ************************************************
   // access decode
   // ************************************************
   // one action per access: only the first cycle of a select counts
   assign acc = host_sel & ~r.sel_d;
   assign wr = acc & host_wr;
   assign rd = acc & ~host_wr;
   assign wr_stop = wr & host_wdata[BIT_STOP];
   assign clr = wr ? host_wdata : '0;
   // while stopped the controller does nothing, so its events are ignored
   assign run = ~r.stop;
   assign babble_flag_set = run & evt.tx_byte & ~evt.tx_frame_start
                     & (r.byte_cnt == BYTE_CNT_W'(BABBLE_BYTES - 1));
   assign tx_kill = evt.tx_underflow | evt.tx_buffer_err;

   // ************************************************
   // next state
   // ************************************************
   always_comb begin
      n = r;
      n.sel_d = host_sel;
      n.stop_pulse = 1'b0;

      // read image frozen at the start of the access
      if (rd) begin
         n.rdata = csr;
      end

      // byte counter for the transmit length watch
      if (evt.tx_frame_start) begin
         n.byte_cnt = '0;
      end else if (evt.tx_byte && r.byte_cnt != BYTE_CNT_W'(BABBLE_BYTES)) begin
         n.byte_cnt = r.byte_cnt + 1'b1;
      end

      // sticky flags: clear first, then set so a concurrent event survives
      n.babble_flag = (r.babble_flag & ~clr[BIT_BABBLE_FLAG]) | babble_flag_set;
      n.collision_error_flag = (r.collision_error_flag & ~clr[BIT_COLLISION_ERROR_FLAG]) | (run & evt.collision_err);
      n.miss = (r.miss & ~clr[BIT_MISS]) | (run & evt.missed);
      n.memory_error_flag = (r.memory_error_flag & ~clr[BIT_MEMORY_ERROR_FLAG]) | (run & memory_error_flag_evt);
      n.receive_event_flag = (r.receive_event_flag & ~clr[BIT_RECEIVE_EVENT_FLAG]) | (run & (evt.rx_done | evt.rx_fail));
      n.transmit_event_flag = (r.transmit_event_flag & ~clr[BIT_TRANSMIT_EVENT_FLAG]) | (run & (evt.tx_done | evt.tx_fail));
      n.initialization_done_flag = (r.initialization_done_flag & ~clr[BIT_INITIALIZATION_DONE_FLAG]) | (run & evt.init_done);

      // interrupt enable takes every write, stopped or not
      if (wr) begin
         n.interrupt_enable_bit = host_wdata[BIT_INTERRUPT_ENABLE_BIT];
      end

      // commands are written with one only; zeros leave them alone
      if (wr && host_wdata[BIT_START_COMMAND]) begin
         n.start_command = 1'b1;
         n.stop = 1'b0;
         if (r.params_ok && !r.disable_receiver_setting) begin
            n.receiver_on_status = 1'b1;
         end
         if (r.params_ok && !r.disable_transmitter_setting) begin
            n.transmitter_on_status = 1'b1;
         end
      end
      if (wr && host_wdata[BIT_INIT]) begin
         n.init = 1'b1;
         n.stop = 1'b0;
      end
      if (wr && host_wdata[BIT_TRANSMIT_DEMAND_BIT] && !r.stop) begin
         n.transmit_demand_bit = 1'b1;
      end else if (evt.transmit_demand_bit_taken) begin
         n.transmit_demand_bit = 1'b0;
      end

      // parameters stored: remember the disable settings
      if (run && evt.init_done) begin
         n.params_ok = 1'b1;
         n.disable_receiver_setting = evt.disable_receiver_setting;
         n.disable_transmitter_setting = evt.disable_transmitter_setting;
         // start written together with initialize comes into force here
         if (evt.disable_receiver_setting) begin
            n.receiver_on_status = 1'b0;
         end else if (r.start_command) begin
            n.receiver_on_status = 1'b1;
         end
         if (evt.disable_transmitter_setting) begin
            n.transmitter_on_status = 1'b0;
         end else if (r.start_command) begin
            n.transmitter_on_status = 1'b1;
         end
      end

      // transmit faults stop the transmitter only
      if (run && tx_kill) begin
         n.transmitter_on_status = 1'b0;
      end

      // a memory error shuts down both directions
      if (run && memory_error_flag_evt) begin
         n.receiver_on_status = 1'b0;
         n.transmitter_on_status = 1'b0;
      end

      // stop overrides everything written with it and acts as a reset
      if (wr_stop) begin
         n = LCS_STATE_RST;
         n.rdata = r.rdata;
         n.sel_d = host_sel;
         n.stop_pulse = 1'b1;
      end

      // pin is built from the next-state flags, so it changes in the same cycle as they do, from a flop
      n.int_n = ~(n.interrupt_enable_bit & (n.babble_flag | n.miss | n.memory_error_flag | n.receive_event_flag | n.transmit_event_flag | n.initialization_done_flag));
   end

   // ************************************************
   // state register
   // ************************************************
   // reset loads the same image that a stop write produces
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         r <= LCS_STATE_RST;
      end else if (ce) begin
         r <= n;
      end
   end

   // ************************************************
   // outputs
   // ************************************************
   assign host_rdata = r.rdata;
   assign int_n = r.int_n;
   assign rx_on = r.receiver_on_status;
   assign tx_on = r.transmitter_on_status;
   assign transmit_demand_bit_pending = r.transmit_demand_bit;
   assign start_on = r.start_command;
   assign init_req = r.init;
   assign stop_on = r.stop;
   assign stop_pulse = r.stop_pulse;

endmodule

// [tb/lcs_host_model.sv]
// partner: host that makes one register access per request
module lcs_host_model import lcs_pkg::*; (
   // request side
   input wire logic clk,
   input wire logic go,
   input wire logic wr,
   input wire logic [CSR_W-1:0] wdata,
   output logic done,
   output logic [CSR_W-1:0] rdata,
   // register slave port
   output logic host_sel,
   output logic host_wr,
   output logic [CSR_W-1:0] host_wdata,
   input wire logic [CSR_W-1:0] host_rdata
);
   logic [1:0] ph = 2'h0;
   initial {done, rdata, host_sel, host_wr, host_wdata} = '0;
   // one select cycle; released lines carry the inverse so stale data never looks valid
   always @(posedge clk) begin
      done <= 1'b0;
      case (ph)
         2'h0: if (go) begin
            host_sel <= 1'b1;
            host_wr <= wr;
            host_wdata <= wdata;
            ph <= 2'h1;
         end
         2'h1: begin
            host_sel <= 1'b0;
            host_wr <= ~host_wr;
            host_wdata <= ~host_wdata;
            ph <= 2'h2;
         end
         default: begin
            rdata <= host_rdata;
            done <= 1'b1;
            ph <= 2'h0;
         end
      endcase
   end
endmodule

// [tb/lcs_main_csr_chk.sv]
// checker: port timing relations of the main control/status register
module lcs_main_csr_chk import lcs_pkg::*; #(
   parameter int MEMORY_ERROR_FLAG_CYC = MEMORY_ERROR_FLAG_TIMEOUT_CYC
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   input wire logic ce,
   // host and master side
   input wire logic host_sel,
   input wire logic host_wr,
   input wire logic [CSR_W-1:0] host_wdata,
   input wire logic [CSR_W-1:0] host_rdata,
   input wire logic bm_addr_strobe,
   input wire logic bm_ready,
   // outputs
   input wire logic int_n,
   input wire logic rx_on,
   input wire logic tx_on,
   input wire logic transmit_demand_bit_pending,
   input wire logic start_on,
   input wire logic init_req,
   input wire logic stop_on,
   input wire logic stop_pulse
);
   logic sel_q;
   logic [15:0] wd_cnt;
   wire tk = ce && host_sel && !sel_q;
   // access edge finder and ready watchdog age; the age saturates so it never wraps
   always_ff @(posedge clk or posedge rst) begin
      if (rst) begin
         sel_q <= 1'b0;
         wd_cnt <= '0;
      end else if (ce) begin
         sel_q <= host_sel;
         if (bm_addr_strobe) wd_cnt <= 16'h0001;
         else if (bm_ready) wd_cnt <= '0;
         else if (wd_cnt != 16'h0000 && wd_cnt != 16'hffff) wd_cnt <= wd_cnt + 16'h0001;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);
   sequence s_wr;
      tk && host_wr;
   endsequence
   sequence s_go;
      s_wr ##0 ((host_wdata[BIT_START_COMMAND] || host_wdata[BIT_INIT]) && !host_wdata[BIT_STOP]);
   endsequence
   a_read_held: assert property (!(tk && !host_wr) |=> $stable(host_rdata)) else $error("read image moved");
   a_stop_quiet: assert property (stop_on |-> !(start_on || init_req || rx_on || tx_on || transmit_demand_bit_pending))
      else $error("activity while stopped");
   a_stop_wr: assert property (s_wr ##0 host_wdata[BIT_STOP] |=> stop_on && stop_pulse ##1 !stop_pulse)
      else $error("stop write not honoured");
   a_go_clears: assert property (s_go |=> !stop_on && (start_on || init_req))
      else $error("start or init did not clear stop");
   a_on_needs_go: assert property ((rx_on || tx_on) |-> start_on) else $error("on without start");
   a_memory_error_flag_off: assert property (wd_cnt == MEMORY_ERROR_FLAG_CYC + 2 |-> !rx_on && !tx_on)
      else $error("no shutdown after ready timeout");
   a_transmit_demand_bit_set: assert property (s_wr ##0 (host_wdata[BIT_TRANSMIT_DEMAND_BIT] && !host_wdata[BIT_STOP] && !stop_on) |=> transmit_demand_bit_pending)
      else $error("transmit demand lost");
   a_pin_idle: assert property (stop_on [*2] |-> int_n) else $error("interrupt while stopped");
endmodule

// [tb/test_lcs_main_csr.sv]
// testbench: host accesses, events and watchdog on the main control/status register
`define CHK(a, b) begin cmp_count++; if ((a) !== (b)) begin n_errors++; \
   $display("[ERR] t=%0t got %h exp %h", $time, (a), (b)); end end
module test_lcs_main_csr import lcs_pkg::*; ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int MC = 20;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ce = 1'b1;
   logic go = 1'b0;
   logic wr = 1'b0;
   logic bm_addr_strobe = 1'b0;
   logic bm_ready = 1'b0;
   logic host_sel, host_wr, done, int_n, rx_on, tx_on, transmit_demand_bit_pending, start_on, init_req, stop_on, stop_pulse;
   logic [CSR_W-1:0] wdata = '0;
   logic [CSR_W-1:0] host_wdata, host_rdata, rdata, e_img;
   logic [15:0] seed = 16'h004f;
   lcs_evt_t evt = '0;
   lcs_evt_t e;
   int n_errors = 0;
   int cmp_count = 0;
   int n_stop_pulse = 0;
   lcs_main_csr #(.MEMORY_ERROR_FLAG_CYC(MC)) DUT (.*);
   lcs_host_model u_host (.*);
   // 250 MHz
   always #2 clk = ~clk;
   // host side duty: every stop pulse means the bus configuration must be rewritten
   always @(posedge clk) begin
      if (stop_pulse === 1'b1) n_stop_pulse++;
   end
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   // flags are babble, collision, missed, mem error, rx, tx, init done
   function automatic logic [CSR_W-1:0] img(input logic [6:0] f, input logic [6:0] lo);
      return {|f[6:3], f, f[6] | (|f[4:0]), lo};
   endfunction
   task automatic tally_and_finish;
      $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   // one access; the event pulse lands on the edge that takes the access
   task automatic acc(input logic w, input logic [CSR_W-1:0] d, input lcs_evt_t ev);
      int k;
      @(posedge clk);
      go <= 1'b1;
      wr <= w;
      wdata <= d;
      @(posedge clk);
      go <= 1'b0;
      evt <= ev;
      @(posedge clk);
      evt <= '0;
      k = 0;
      while (done !== 1'b1 && k < 8) begin
         @(negedge clk);
         k++;
      end
      if (k == 8) n_errors++;
   endtask
   // hang guard, far beyond the few thousand cycles the tests need
   initial begin
      #40000;
      n_errors++;
      tally_and_finish();
   end
   // main sequence
   initial begin
      repeat (6) @(posedge clk);
      rst <= 1'b0;
      acc(1'b0, '0, '0);
      `CHK(rdata, CSR_RESET_VALUE)
      acc(1'b1, 16'h0040, '0);
      acc(1'b0, '0, '0);
      `CHK(rdata, 16'h0044)
      acc(1'b1, 16'h0041, '0);
      e = '0;
      e.init_done = 1'b1;
      acc(1'b0, '0, e);
      acc(1'b0, '0, '0);
      `CHK(rdata, 16'h01c1)
      `CHK(int_n, 1'b0)
      acc(1'b1, 16'h0142, '0);
      acc(1'b0, '0, '0);
      `CHK(rdata, 16'h0073)
      `CHK(int_n, 1'b1)
      $display("test init and start done");
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         e = '0;
         e.rx_done = seed[0];
         e.tx_done = seed[1];
         e.missed = seed[2];
         e.collision_err = seed[3];
         acc(1'b0, '0, e);
         acc(1'b0, '0, '0);
         e_img = img({1'b0, seed[3], seed[2], 1'b0, seed[0], seed[1], 1'b0}, 7'h73);
         `CHK(rdata, e_img)
         `CHK(int_n, ~e_img[BIT_INTERRUPT_SUMMARY_FLAG])
         acc(1'b1, 16'h7f40, '0);
      end
      e = '0;
      e.rx_done = 1'b1;
      acc(1'b1, 16'h0440, e);
      acc(1'b0, '0, '0);
      `CHK(rdata, img(7'h04, 7'h73))
      acc(1'b1, 16'h0440, '0);
      $display("test event flags done");
      acc(1'b1, 16'h0048, '0);
      `CHK(transmit_demand_bit_pending, 1'b1)
      e = '0;
      e.transmit_demand_bit_taken = 1'b1;
      acc(1'b0, '0, e);
      `CHK(transmit_demand_bit_pending, 1'b0)
      for (int j = 0; j < 2; j++) begin
         @(posedge clk);
         bm_addr_strobe <= 1'b1;
         @(posedge clk);
         bm_addr_strobe <= 1'b0;
         repeat (5) @(posedge clk);
         bm_ready <= (j == 0);
         @(posedge clk);
         bm_ready <= 1'b0;
         repeat (MC + 4) @(posedge clk);
         acc(1'b0, '0, '0);
         `CHK(rdata, j ? img(7'h08, 7'h43) : 16'h0073)
         `CHK({rx_on, tx_on}, j ? 2'h0 : 2'h3)
      end
      $display("test demand and watchdog done");
      // over-long frame: start marker, then exactly the babble byte count
      e = '0;
      e.tx_frame_start = 1'b1;
      @(posedge clk);
      evt <= e;
      e = '0;
      e.tx_byte = 1'b1;
      for (int b = 0; b < BABBLE_BYTES; b++) @(posedge clk) evt <= e;
      @(posedge clk);
      evt <= '0;
      acc(1'b0, '0, '0);
      `CHK(rdata, img(7'h48, 7'h43))
      acc(1'b1, 16'h0047, '0);
      `CHK(n_stop_pulse, 1)
      acc(1'b0, '0, '0);
      `CHK(rdata, 16'h0004)
      `CHK(int_n, 1'b1)
      acc(1'b1, 16'h0042, '0);
      @(posedge clk);
      rst <= 1'b1;
      repeat (2) @(posedge clk);
      rst <= 1'b0;
      acc(1'b0, '0, '0);
      `CHK(rdata, 16'h0004)
      $display("test stop and reset done");
      tally_and_finish();
   end
endmodule
bind lcs_main_csr lcs_main_csr_chk #(.MEMORY_ERROR_FLAG_CYC(MEMORY_ERROR_FLAG_CYC)) u_chk (.*);
